// [dv/wlf_checker.sv]
// port assertions for the write leveling feedback block
`default_nettype none
module wlf_checker #(
    parameter WIDE = 1
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        odtPin,
    input wire logic        lowerLaneStrobe,
    input wire logic [15:0] dqOut,
    input wire logic [15:0] dqOe,
    input wire logic [1:0]  strobeTermOn,
    input wire logic        strobeInputMode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence setup_s; psel && !penable; endsequence
    sequence answer_s; pready ##1 !pready; endsequence
    // eight quiet cycles cover the three-flop sync, the capture flop and the output flop
    sequence quiet_s; (strobeInputMode && !lowerLaneStrobe)[*8] ##1 strobeInputMode; endsequence
    apb_answer_a: assert property (setup_s |=> answer_s)
        else $error("ready not single after setup");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    quiet_lines_a: assert property (dqOut[7:1] == 0 && dqOut[15:9] == 0)
        else $error("non-prime line high");
    drive_width_a: assert property (
        strobeInputMode |-> dqOe == (WIDE ? 16'hFFFF : 16'h00FF))
        else $error("wrong drive set");
    highz_off_a: assert property (!strobeInputMode |-> dqOe == 0)
        else $error("data driven while not capturing");
    odt_low_a: assert property ((!odtPin)[*8] |-> strobeTermOn == 2'b00)
        else $error("termination on with odt low");
    term_on_a: assert property ((odtPin && strobeInputMode)[*8] |-> strobeTermOn[0])
        else $error("termination off with odt high");
    hold_sample_a: assert property (quiet_s |-> $stable(dqOut[0]))
        else $error("feedback changed without strobe");
endmodule // wlf_checker
bind wlf_feedback wlf_checker #(.WIDE(WIDE)) chk (
    .clk_sys, .resetn, .psel, .penable, .pready, .pslverr, .odtPin,
    .lowerLaneStrobe, .dqOut, .dqOe, .strobeTermOn, .strobeInputMode
);
`default_nettype wire

// [dv/wlf_ctrl_model.sv]
// controller model: free running device clock and delayed lane strobes
`default_nettype none
module wlf_ctrl_model (
    input  wire logic clk_sys,
    output wire logic ckPin,
    output var  logic lowerLaneStrobe,
    output var  logic upperLaneStrobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] ckPhase_r = 4'h0;
    initial lowerLaneStrobe = 1'b0;
    initial upperLaneStrobe = 1'b0;
    always @(posedge clk_sys) ckPhase_r <= ckPhase_r + 4'h1;
    // device clock high for phases 0..7, period sixteen cycles
    assign ckPin = ~ckPhase_r[3];
    // strobe d cycles after clock rise; upper lane skewed half a clock
    // no command bus here: only clock and strobes, as nop or deselect would leave it
    task automatic toggle(input int d);
        @(posedge clk_sys iff ckPhase_r == 4'hF);
        repeat (d) @(posedge clk_sys);
        lowerLaneStrobe <= 1'b1;
        repeat (4) @(posedge clk_sys);
        lowerLaneStrobe <= 1'b0;
        repeat (4) @(posedge clk_sys);
        upperLaneStrobe <= 1'b1;
        repeat (4) @(posedge clk_sys);
        upperLaneStrobe <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // wlf_ctrl_model
`default_nettype wire

// [dv/wlf_feedback_tb.sv]
// bench for the write leveling feedback block
`default_nettype none
`include "wlf_consts.vh"
module wlf_feedback_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        odtPin = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, ckPin, lowerLaneStrobe, upperLaneStrobe;
    logic        strobeInputMode;
    logic [15:0] dqOut, dqOe;
    logic [1:0]  strobeTermOn;
    int          nErrors = 0;
    int          checkCount = 0;
    wlf_feedback #(.WIDE(1)) uut (.clk_sys, .resetn, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr, .ckPin, .odtPin,
        .lowerLaneStrobe, .upperLaneStrobe, .dqOut, .dqOe, .strobeTermOn,
        .strobeInputMode);
    wlf_ctrl_model ctl (.clk_sys, .ckPin, .lowerLaneStrobe, .upperLaneStrobe);
    always #50 clk_sys = ~clk_sys;
    task automatic finishTest;
        $display("checks %0d errors %0d", checkCount, nErrors);
        if (nErrors == 0 && checkCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle edge before setup keeps each signal to one assignment per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            nErrors++;
            finishTest();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        apb(0, `WLF_ADDR_CTRL, 0);
        check(rd, 32'h0000_0000);
        check(dqOe, 16'h0000);
        apb(0, `WLF_ADDR_STAT, 0);
        check(rd, 32'h0000_0080);
        apb(1, 8'h0C, 32'hFFFF_FFFF);
        check(err, 1'b1);
        apb(0, 8'h0C, 0);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        apb(1, `WLF_ADDR_CTRL, 32'h0000_0080);
        repeat (2) @(posedge clk_sys);
        check({strobeInputMode, dqOe, strobeTermOn}, 19'h7_FFFC);
        // sweep delay past the 0-to-1 clock transition on the lower lane
        for (int d = 9; d <= 17; d += 2) begin
            ctl.toggle(d);
            check(dqOut, {7'h00, (d + 8) % 16 < 8, 7'h00, d % 16 < 8});
        end
        apb(0, `WLF_ADDR_CNT, 0);
        check(rd, 32'h0000_0505);
        odtPin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        apb(1, `WLF_ADDR_CTRL, 32'h0000_0084);
        apb(0, `WLF_ADDR_STAT, 0);
        check(rd[6:2], 5'b01111);
        check({strobeTermOn, dqOe}, 18'h3_FFFF);
        apb(1, `WLF_ADDR_CTRL, 32'h0000_0280);
        apb(0, `WLF_ADDR_STAT, 0);
        check(rd[6], 1'b1);
        apb(1, `WLF_ADDR_CTRL, 32'h0000_1280);
        apb(0, `WLF_ADDR_STAT, 0);
        check(rd[6:2], 5'b01101);
        check({strobeInputMode, dqOe, strobeTermOn}, 19'h0_0003);
        ctl.toggle(3);
        apb(0, `WLF_ADDR_CNT, 0);
        check(rd, 32'h0000_0505);
        apb(1, `WLF_ADDR_CNT, 0);
        apb(0, `WLF_ADDR_CNT, 0);
        check(rd, 32'h0000_0000);
        apb(1, `WLF_ADDR_CTRL, 0);
        odtPin <= 1'b0;
        repeat (8) @(posedge clk_sys);
        check({strobeInputMode, dqOe, strobeTermOn}, 19'h0_0000);
        finishTest();
    end
endmodule // wlf_feedback_tb
`default_nettype wire

// [src/wlf_consts.vh]
// constants for the write leveling feedback block
`ifndef WLF_CONSTS_VH
`define WLF_CONSTS_VH

// register byte addresses
`define WLF_ADDR_CTRL    8'h00
`define WLF_ADDR_STAT    8'h04
`define WLF_ADDR_CNT     8'h08
`define WLF_ADDR_W       8

// mode bits inside the control word
`define WLF_BIT_LVL_EN   7
`define WLF_BIT_OUT_OFF  12
`define WLF_BIT_TERM0    2
`define WLF_BIT_TERM1    6
`define WLF_BIT_TERM2    9
`define WLF_CTRL_RST     32'h0000_0000
`define WLF_CTRL_MASK    32'h0000_1284

// status word fields
`define WLF_ST_SMP_LO    0
`define WLF_ST_SMP_HI    1
`define WLF_ST_LVL_ON    2
`define WLF_ST_DRIVING   3
`define WLF_ST_ODT       4
`define WLF_ST_TERM_ON   5
`define WLF_ST_TERM_BAD  6
`define WLF_ST_WIDE      7
`define WLF_ST_SEEN_LO   8
`define WLF_ST_SEEN_HI   9

// termination codes allowed while capturing (one bit per code)
`define WLF_TERM_WR_OK   8'h0E

// edge counter width per lane
`define WLF_CNT_W        8

`endif

// [src/wlf_feedback.v]
// write leveling feedback logic of the memory device, with apb register access
//
// How it works
// - rising strobe edge samples clock, shown on prime
// - feedback path fixed latency, no read pipeline
// - byte-wide: data line 0 prime, 7:1 low
// - 16-bit: lines 0 and 8 prime, rest low
// - leveling-enable bit 7 selects leveling mode
// - output-buffer-off bit 12 gates feedback drive
// - strobe input, data output while leveling
// - odt switches strobe termination only
// - outputs off: strobe ignored, data high-z
// - capture with odt: termination 40, 60, 120; WLF_CTRL_MASK drops bit 6, so of codes 1-3 only code 1 can be set
// - odt low: unterminated strobe, drive feedback
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
`include "wlf_consts.vh"

module wlf_feedback #(
    parameter WIDE = 1
) (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ckPin,
    input  wire        odtPin,
    input  wire        lowerLaneStrobe,
    input  wire        upperLaneStrobe,
    output reg  [15:0] dqOut,
    output reg  [15:0] dqOe,
    output reg  [1:0]  strobeTermOn,
    output reg         strobeInputMode
);

    // register file
    reg  [31:0]               modeReg_r;
    reg  [`WLF_CNT_W-1:0]     cntLo_r;
    reg  [`WLF_CNT_W-1:0]     cntHi_r;
    reg                       seenLo_r;
    reg                       seenHi_r;

    // pin synchronisers for clock and odt
    reg                       ckMeta_r;
    reg                       ckSync2_r;
    reg                       ckSync3_r;
    reg                       ckLevel_r;
    reg                       odtMeta_r;
    reg                       odtSync2_r;
    reg                       odtSync3_r;
    reg                       odtLevel_r;

    // lane results
    wire                      smpLo;
    wire                      smpHi;
    wire                      riseLo;
    wire                      riseHi;

    // decoded mode
    wire                      levelingOn;
    wire                      outputsOff;
    wire                      capturing;
    wire [2:0]                termCode;
    wire [7:0]                termOkMask;
    wire                      termBad;
    wire                      wideCfg;

    // bus decode
    wire                      setupPhase;
    wire                      accessDone;
    wire                      wrDone;
    reg  [31:0]               rdData;
    reg                       addrHit;
    reg  [31:0]               statWord;

    // address decode, used by the read mux and the mapped check
    function [2:0] regSel;
        input [`WLF_ADDR_W-1:0] addr;
        begin
            case (addr)
                `WLF_ADDR_CTRL: regSel = 3'b001;
                `WLF_ADDR_STAT: regSel = 3'b010;
                `WLF_ADDR_CNT:  regSel = 3'b100;
                default:        regSel = 3'b000;
            endcase
        end
    endfunction

    assign wideCfg    = (WIDE != 0);

    // mode bits
    assign levelingOn = modeReg_r[`WLF_BIT_LVL_EN];
    assign outputsOff = modeReg_r[`WLF_BIT_OUT_OFF];
    assign capturing  = levelingOn & ~outputsOff;
    assign termCode   = {modeReg_r[`WLF_BIT_TERM2],
                         modeReg_r[`WLF_BIT_TERM1],
                         modeReg_r[`WLF_BIT_TERM0]};

    // only some termination values are usable while the strobe is captured
    assign termOkMask = `WLF_TERM_WR_OK;
    assign termBad    = capturing & odtLevel_r & ~termOkMask[termCode];

    // clock and odt pins: three stages, change counts when two and three agree
    always @(posedge clk_sys) begin
        if (!resetn) begin
            ckMeta_r   <= 1'b0;
            ckSync2_r  <= 1'b0;
            ckSync3_r  <= 1'b0;
            ckLevel_r  <= 1'b0;
            odtMeta_r  <= 1'b0;
            odtSync2_r <= 1'b0;
            odtSync3_r <= 1'b0;
            odtLevel_r <= 1'b0;
        end else begin
            ckMeta_r   <= ckPin;
            ckSync2_r  <= ckMeta_r;
            ckSync3_r  <= ckSync2_r;
            odtMeta_r  <= odtPin;
            odtSync2_r <= odtMeta_r;
            odtSync3_r <= odtSync2_r;
            if (ckSync2_r == ckSync3_r) begin
                ckLevel_r <= ckSync2_r;
            end
            if (odtSync2_r == odtSync3_r) begin
                odtLevel_r <= odtSync2_r;
            end
        end
    end

    // lower lane always present
    wlf_lane uLaneLo (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .strobePin   (lowerLaneStrobe),
        .ckLevel     (ckLevel_r),
        .captureEn   (capturing),
        .sampleLvl_r (smpLo),
        .risePulse_r (riseLo)
    );

    // upper lane only in the 16-bit configuration
    generate
        if (WIDE != 0) begin : gUpper
            wlf_lane uLaneHi (
                .clk_sys     (clk_sys),
                .resetn      (resetn),
                .strobePin   (upperLaneStrobe),
                .ckLevel     (ckLevel_r),
                .captureEn   (capturing),
                .sampleLvl_r (smpHi),
                .risePulse_r (riseHi)
            );
        end else begin : gNoUpper
            assign smpHi  = 1'b0;
            assign riseHi = 1'b0;
        end
    endgenerate

    // data pins: prime lines carry the sample, the others drive low; byte-wide leaves lines 15:8 high-z
    always @(posedge clk_sys) begin
        if (!resetn) begin
            dqOut <= 16'h0000;
            dqOe  <= 16'h0000;
        end else if (capturing) begin
            // straight from the capture flop, no read latency
            dqOut    <= 16'h0000;
            dqOut[0] <= smpLo;
            dqOut[8] <= smpHi & wideCfg;
            dqOe     <= wideCfg ? 16'hFFFF : 16'h00FF;
        end else begin
            // outputs off or leveling off: all data lines high-z
            dqOut <= 16'h0000;
            dqOe  <= 16'h0000;
        end
    end

    // strobe termination follows odt while leveling; data never terminated
    always @(posedge clk_sys) begin
        if (!resetn) begin
            strobeTermOn    <= 2'b00;
            strobeInputMode <= 1'b0;
        end else begin
            strobeTermOn[0] <= levelingOn & odtLevel_r;
            strobeTermOn[1] <= levelingOn & odtLevel_r & wideCfg;
            strobeInputMode <= capturing;
        end
    end

    // status word assembly
    always @* begin
        statWord                    = 32'h0000_0000;
        statWord[`WLF_ST_SMP_LO]    = smpLo;
        statWord[`WLF_ST_SMP_HI]    = smpHi;
        statWord[`WLF_ST_LVL_ON]    = levelingOn;
        statWord[`WLF_ST_DRIVING]   = capturing;
        statWord[`WLF_ST_ODT]       = odtLevel_r;
        statWord[`WLF_ST_TERM_ON]   = levelingOn & odtLevel_r;
        statWord[`WLF_ST_TERM_BAD]  = termBad;
        statWord[`WLF_ST_WIDE]      = wideCfg;
        statWord[`WLF_ST_SEEN_LO]   = seenLo_r;
        statWord[`WLF_ST_SEEN_HI]   = seenHi_r;
    end

    // apb: data prepared in setup, answered in the first access cycle
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;
    // pslverr stands with pready, so it marks an unmapped write in the access cycle
    assign wrDone     = accessDone & pwrite & ~pslverr;

    always @* begin
        rdData  = 32'h0000_0000;
        addrHit = 1'b1;
        case (regSel(paddr))
            3'b001:  rdData = modeReg_r;
            3'b010:  rdData = statWord;
            3'b100:  rdData = {16'h0000, cntHi_r, cntLo_r};
            default: addrHit = 1'b0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // one cycle of pready per transfer
            pready  <= setupPhase;
            pslverr <= setupPhase & ~addrHit;
            if (setupPhase && !pwrite) begin
                prdata <= addrHit ? rdData : 32'h0000_0000;
            end
        end
    end

    // mode register; leaving leveling is the controller's job
    always @(posedge clk_sys) begin
        if (!resetn) begin
            modeReg_r <= `WLF_CTRL_RST;
        end else if (wrDone && regSel(paddr) == 3'b001) begin
            modeReg_r <= pwdata & `WLF_CTRL_MASK;
        end
    end

    // strobe edge counters and seen flags; a new edge beats a clear
    always @(posedge clk_sys) begin
        if (!resetn) begin
            cntLo_r  <= {`WLF_CNT_W{1'b0}};
            cntHi_r  <= {`WLF_CNT_W{1'b0}};
            seenLo_r <= 1'b0;
            seenHi_r <= 1'b0;
        end else begin
            if (wrDone && regSel(paddr) == 3'b100) begin
                cntLo_r <= {{(`WLF_CNT_W-1){1'b0}}, riseLo};
                cntHi_r <= {{(`WLF_CNT_W-1){1'b0}}, riseHi};
            end else begin
                // counters saturate so a long sweep never wraps to zero
                if (riseLo && cntLo_r != {`WLF_CNT_W{1'b1}}) begin
                    cntLo_r <= cntLo_r + {{(`WLF_CNT_W-1){1'b0}}, 1'b1};
                end
                if (riseHi && cntHi_r != {`WLF_CNT_W{1'b1}}) begin
                    cntHi_r <= cntHi_r + {{(`WLF_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            if (riseLo) begin
                seenLo_r <= 1'b1;
            end else if (wrDone && regSel(paddr) == 3'b010
                         && pwdata[`WLF_ST_SEEN_LO]) begin
                seenLo_r <= 1'b0;
            end
            if (riseHi) begin
                seenHi_r <= 1'b1;
            end else if (wrDone && regSel(paddr) == 3'b010
                         && pwdata[`WLF_ST_SEEN_HI]) begin
                seenHi_r <= 1'b0;
            end
        end
    end

endmodule // wlf_feedback

`default_nettype wire

// [src/wlf_lane.v]
// one byte lane: strobe synchroniser, rising edge capture of the clock level
`default_nettype none

module wlf_lane (
    input  wire clk_sys,
    input  wire resetn,
    input  wire strobePin,
    input  wire ckLevel,
    input  wire captureEn,
    output reg  sampleLvl_r,
    output reg  risePulse_r
);

    reg  stbMeta_r;
    reg  stbSync2_r;
    reg  stbSync3_r;
    reg  stbLevel_r;
    wire stbAgree;
    wire stbRise;

    // first stage feeds only the second stage
    always @(posedge clk_sys) begin
        if (!resetn) begin
            stbMeta_r  <= 1'b0;
            stbSync2_r <= 1'b0;
            stbSync3_r <= 1'b0;
        end else begin
            stbMeta_r  <= strobePin;
            stbSync2_r <= stbMeta_r;
            stbSync3_r <= stbSync2_r;
        end
    end

    // a change counts only once stages two and three agree
    assign stbAgree = (stbSync2_r == stbSync3_r);
    assign stbRise  = stbAgree & stbSync2_r & ~stbLevel_r;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            stbLevel_r  <= 1'b0;
            sampleLvl_r <= 1'b0;
            risePulse_r <= 1'b0;
        end else begin
            if (stbAgree) begin
                stbLevel_r <= stbSync2_r;
            end
            // strobe ignored while outputs are off
            risePulse_r <= stbRise & captureEn;
            if (stbRise && captureEn) begin
                sampleLvl_r <= ckLevel;
            end
            // otherwise the last sample is held
        end
    end

endmodule // wlf_lane

`default_nettype wire
